// File: verilog/pmbus_limit_pkg.sv
package pmbus_limit_pkg;

  // command codes seen on the transaction port
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_STOP_THRESH = 8'h36;
  localparam logic [7:0] CMD_CURR_OFFSET = 8'h39;
  localparam logic [7:0] CMD_OV_LIMIT = 8'h40;

  // linear word layout: exponent above, mantissa below
  localparam int EXP_LSB = 11;
  localparam int MANT_W = 11;
  localparam int SIGN_BIT = 10;
  localparam int OFFS_LOW_W = 6;
  localparam int OFFS_EXT_W = 4;
  localparam int STOP_W = 5;
  localparam int STOP_PAD_W = MANT_W - STOP_W;

  // input stop threshold, quarter-volt counts
  localparam logic [4:0] STOP_EXP = 5'h1e;
  localparam int STOP_EXP_VAL = -2;
  localparam logic [4:0] STOP_MIN = 5'h10;
  localparam logic [4:0] STOP_MAX = 5'h1e;
  localparam logic [4:0] STOP_RESET = 5'h10;
  localparam logic [4:0] START_MIN = 5'h11;
  localparam logic [4:0] START_MAX = 5'h1f;

  // current offset trim, 62.5 mA counts
  localparam logic [4:0] OFFS_EXP = 5'h1c;
  localparam logic [5:0] OFFS_LOW_RESET = 6'h00;

  // overvoltage trip limit, exponent -9 implied
  localparam logic [15:0] OV_RESET = 16'h0290;
  localparam logic [18:0] OV_CEIL_X4 = 19'h0e68; // 922 scaled by the ratio's quarter units
  localparam logic [15:0] NV_KEEP_MASK = 16'hfff0;

  // one command from the serial front end
  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } cmd_t;

  // image handed to non-volatile storage
  typedef struct packed {
    logic [15:0] stop_word;
    logic [15:0] offset_word;
    logic [15:0] ov_word;
  } nv_image_t;

endpackage : pmbus_limit_pkg

// File: verilog/pmbus_limit_config_regs.sv
`timescale 1ns/1ps
// Function
// - in-range stop writes round to quarter volt
// - out-of-range stop write flags, alerts, keeps value
// - stop mantissa valid only 16 to 30
// - stop below start, else reject
// - stop word: 5-bit exponent, 11-bit mantissa
// - stop exponent reads constant minus two
// - stop mantissa resets to 16
// - store-all copies three registers to nonvolatile
// - overvoltage limit loses low four bits stored
// - offset corrects current reading and thresholds
// - offset 62.5 mA steps, resets zero
// - offset writes wrap silently, never flagged
// - offset exponent minus four, sign extended
// - bad overvoltage write flags and alerts
// - limit above warning, below 922 over ratio
// - overvoltage limit unsigned, exponent minus nine
// - overvoltage limit resets to 656
// - start threshold range 17 to 31
module pmbus_limit_config_regs
  import pmbus_limit_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  input wire logic [4:0] input_start_threshold,
  input wire logic [15:0] overvoltage_warning_limit,
  input wire logic [2:0] feedback_divider_ratio,
  input wire logic [15:0] output_current_raw,
  input wire logic [15:0] overcurrent_trip_raw,
  input wire logic [15:0] overcurrent_warning_raw,
  output logic rd_valid_q,
  output logic [15:0] rd_data_q,
  output logic cml_flag_q,
  output logic ivd_flag_q,
  output logic smbalert_out_q,
  output logic smbalert_oe_n_q,
  output logic nv_store_q,
  output nv_image_t nv_image_q,
  output logic [15:0] output_current_reading_q,
  output logic [15:0] overcurrent_trip_limit_q,
  output logic [15:0] overcurrent_warning_limit_q
);

  logic [4:0] stop_q;
  logic offs_sign_q;
  logic [5:0] offs_low_q;
  logic [15:0] ov_q;

  logic [15:0] stop_word;
  logic [15:0] offset_word;
  logic [15:0] offset_ext;
  logic [4:0] start_eff;
  logic wr_stop, wr_offs, wr_ov, rd_cmd, do_store, do_clear;
  logic stop_ok, ov_ok, bad_write;
  logic [4:0] stop_new;
  logic [18:0] ov_scaled;
  logic cml_d, ivd_d;

  // convert a linear word into quarter-volt counts, rounding half up
  function automatic int to_quarter(input logic [15:0] w);
    int e;
    int m;
    int s;
    int r;
    e = int'($signed(w[15:EXP_LSB]));
    m = int'($signed(w[MANT_W-1:0]));
    s = e - STOP_EXP_VAL;
    if (s >= 0) begin
      r = m <<< s;
    end else begin
      r = (m + (1 <<< (-s - 1))) >>> (-s);
    end
    return r;
  endfunction : to_quarter

  // command decode
  assign wr_stop = cmd_valid && cmd.write && (cmd.code == CMD_STOP_THRESH);
  assign wr_offs = cmd_valid && cmd.write && (cmd.code == CMD_CURR_OFFSET);
  assign wr_ov = cmd_valid && cmd.write && (cmd.code == CMD_OV_LIMIT);
  assign do_store = cmd_valid && cmd.write && (cmd.code == CMD_STORE_ALL);
  assign do_clear = cmd_valid && cmd.write && (cmd.code == CMD_CLEAR_FAULTS);
  assign rd_cmd = cmd_valid && !cmd.write;

  // assembled read words with fixed fields
  assign stop_word = {STOP_EXP, {STOP_PAD_W{1'b0}}, stop_q};
  assign offset_word = {OFFS_EXP, offs_sign_q, {OFFS_EXT_W{offs_sign_q}}, offs_low_q};
  assign offset_ext = {{(16 - OFFS_LOW_W){offs_sign_q}}, offs_low_q};

  // start threshold held inside its own legal span
  always_comb begin
    start_eff = input_start_threshold;
    if (input_start_threshold < START_MIN) begin
      start_eff = START_MIN;
    end
    if (input_start_threshold > START_MAX) begin
      start_eff = START_MAX;
    end
  end

  // range and ordering checks for the checked registers
  always_comb begin
    int q;
    q = to_quarter(cmd.data);
    stop_ok = (q >= int'(STOP_MIN)) && (q <= int'(STOP_MAX));
    stop_new = stop_ok ? q[STOP_W-1:0] : stop_q;
    if (stop_ok && (stop_new >= start_eff)) begin
      stop_ok = 1'b0;
    end
    ov_scaled = 19'(cmd.data) * 19'(feedback_divider_ratio);
    ov_ok = (cmd.data > overvoltage_warning_limit) && (ov_scaled < OV_CEIL_X4);
    bad_write = (wr_stop && !stop_ok) || (wr_ov && !ov_ok);
  end

  // stop threshold storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stop_q <= STOP_RESET;
    end else if (wr_stop && stop_ok) begin
      stop_q <= stop_new;
    end
  end

  // offset trim storage: only sign and low bits are kept, so writes wrap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      offs_sign_q <= 1'b0;
      offs_low_q <= OFFS_LOW_RESET;
    end else if (wr_offs) begin
      offs_sign_q <= cmd.data[SIGN_BIT];
      offs_low_q <= cmd.data[OFFS_LOW_W-1:0];
    end
  end

  // overvoltage trip limit storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ov_q <= OV_RESET;
    end else if (wr_ov && ov_ok) begin
      ov_q <= cmd.data;
    end
  end

  // fault flags: a new fault wins over a clear in the same cycle
  always_comb begin
    cml_d = cml_flag_q;
    ivd_d = ivd_flag_q;
    if (do_clear) begin
      cml_d = 1'b0;
      ivd_d = 1'b0;
    end
    if (bad_write) begin
      cml_d = 1'b1;
      ivd_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cml_flag_q <= 1'b0;
      ivd_flag_q <= 1'b0;
    end else begin
      cml_flag_q <= cml_d;
      ivd_flag_q <= ivd_d;
    end
  end

  // open-drain alert: pulled low while a fault stays latched
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      smbalert_out_q <= 1'b0;
      smbalert_oe_n_q <= 1'b1;
    end else begin
      smbalert_out_q <= 1'b0;
      smbalert_oe_n_q <= !cml_d;
    end
  end

  // read answers one cycle after the request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end else begin
      rd_valid_q <= rd_cmd;
      if (rd_cmd) begin
        unique case (cmd.code)
          CMD_STOP_THRESH: rd_data_q <= stop_word;
          CMD_CURR_OFFSET: rd_data_q <= offset_word;
          CMD_OV_LIMIT: rd_data_q <= ov_q;
          default: rd_data_q <= 16'h0000; // unmapped codes read zero
        endcase
      end
    end
  end

  // store-all snapshot, low bits of the limit are not kept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nv_store_q <= 1'b0;
      nv_image_q <= '0;
    end else begin
      nv_store_q <= do_store;
      if (do_store) begin
        nv_image_q.stop_word <= stop_word;
        nv_image_q.offset_word <= offset_word;
        nv_image_q.ov_word <= ov_q & NV_KEEP_MASK;
      end
    end
  end

  // offset correction of reading and both thresholds
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      output_current_reading_q <= 16'h0000;
      overcurrent_trip_limit_q <= 16'h0000;
      overcurrent_warning_limit_q <= 16'h0000;
    end else begin
      output_current_reading_q <= output_current_raw + offset_ext;
      overcurrent_trip_limit_q <= overcurrent_trip_raw + offset_ext;
      overcurrent_warning_limit_q <= overcurrent_warning_raw + offset_ext;
    end
  end

  // checks
  sequence s_bad_stop;
    wr_stop && !stop_ok;
  endsequence

  sequence s_store_req;
    do_store;
  endsequence

  a_stop_reject: assert property (@(posedge clk) disable iff (!nrst)
    s_bad_stop |=> (stop_q == $past(stop_q)) && ivd_flag_q && cml_flag_q && !smbalert_oe_n_q)
    else $error("bad stop write altered value or missed flags");

  a_stop_range: assert property (@(posedge clk) disable iff (!nrst)
    (stop_q >= STOP_MIN) && (stop_q <= STOP_MAX))
    else $error("stop threshold left its range");

  a_stop_order: assert property (@(posedge clk) disable iff (!nrst)
    wr_stop && stop_ok |=> stop_q < $past(start_eff))
    else $error("accepted stop not below start");

  a_stop_read: assert property (@(posedge clk) disable iff (!nrst)
    rd_cmd && (cmd.code == CMD_STOP_THRESH) |=> rd_valid_q && (rd_data_q[15:EXP_LSB] == STOP_EXP))
    else $error("stop exponent read wrong");

  a_offset_wrap: assert property (@(posedge clk) disable iff (!nrst)
    wr_offs && !ivd_flag_q && !do_clear |=> !ivd_flag_q ##0 offs_sign_q == $past(cmd.data[SIGN_BIT]))
    else $error("offset write flagged or not wrapped");

  a_ov_reject: assert property (@(posedge clk) disable iff (!nrst)
    wr_ov && (cmd.data <= overvoltage_warning_limit) |=> (ov_q == $past(ov_q)) && ivd_flag_q)
    else $error("limit at or under warning accepted");

  a_ov_bounds: assert property (@(posedge clk) disable iff (!nrst)
    wr_ov && ov_ok |=> ov_q == $past(cmd.data))
    else $error("valid limit not stored");

  a_store_pulse: assert property (@(posedge clk) disable iff (!nrst)
    s_store_req ##1 !do_store |-> nv_store_q ##1 !nv_store_q)
    else $error("store pulse wrong length");

  a_nv_mask: assert property (@(posedge clk) disable iff (!nrst)
    s_store_req |=> nv_image_q.ov_word == ($past(ov_q) & NV_KEEP_MASK))
    else $error("stored limit kept low bits");

  a_alert_flag: assert property (@(posedge clk) disable iff (!nrst)
    smbalert_oe_n_q == !cml_flag_q)
    else $error("alert does not follow fault flag");

  a_current_corr: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && !$past(wr_offs) |-> output_current_reading_q == 16'($past(output_current_raw) + offset_ext))
    else $error("current reading not corrected");

endmodule : pmbus_limit_config_regs

// File: dv/pmbus_host_model.sv
`timescale 1ns/1ps
// host side of the command port: one word per command
module pmbus_host_model
  import pmbus_limit_pkg::*;
(
  input wire logic clk,
  output logic cmd_valid,
  output cmd_t cmd
);
  // idle at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // hold the command over one taking edge, then scramble the idle word so a
  // stale value never looks valid; the top sets start at or below stop once
  task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] data);
    cmd_valid = 1'b1;
    cmd = '{write: w, code: code, data: data};
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd = ~cmd;
    @(posedge clk);
    #1;
  endtask : xfer
endmodule : pmbus_host_model

// File: dv/pmbus_limit_config_regs_tb_top.sv
`timescale 1ns/1ps
module pmbus_limit_config_regs_tb_top;
  import pmbus_limit_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid;
  cmd_t cmd;
  logic [4:0] start_thr = 5'h1f;
  logic [15:0] ov_warn = 16'h0200;
  logic [2:0] ratio = 3'h4;
  logic [15:0] i_raw = 16'h0010;
  logic [15:0] oc_raw = 16'h0040;
  logic [15:0] ow_raw = 16'hfff0;
  logic rd_valid, cml, ivd, alert_out, alert_oe_n, nv_store;
  logic [15:0] rd_data, i_rd, oc_lim, ow_lim;
  nv_image_t nv_image;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  pmbus_host_model pmbus_host_model_i (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd));

  pmbus_limit_config_regs pmbus_limit_config_regs_i (
    .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
    .input_start_threshold(start_thr), .overvoltage_warning_limit(ov_warn),
    .feedback_divider_ratio(ratio), .output_current_raw(i_raw),
    .overcurrent_trip_raw(oc_raw), .overcurrent_warning_raw(ow_raw),
    .rd_valid_q(rd_valid), .rd_data_q(rd_data), .cml_flag_q(cml), .ivd_flag_q(ivd),
    .smbalert_out_q(alert_out), .smbalert_oe_n_q(alert_oe_n), .nv_store_q(nv_store),
    .nv_image_q(nv_image), .output_current_reading_q(i_rd),
    .overcurrent_trip_limit_q(oc_lim), .overcurrent_warning_limit_q(ow_lim)
  );

  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    pmbus_host_model_i.xfer(1'b1, code, data);
  endtask : wr

  // read answer stands one cycle, checked right there
  // the answer is looked at just after the taking edge, while the valid pulse stands
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    fork
      pmbus_host_model_i.xfer(1'b0, code, 16'h0000);
      begin
        @(posedge clk);
        #1;
        check({rd_valid, rd_data}, {1'b1, exp});
      end
    join
  endtask : rd

  // cml, ivd, alert enable (low = pulled), alert level
  task automatic flags(input logic [3:0] exp);
    check({cml, ivd, alert_oe_n, alert_out}, exp);
  endtask : flags

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    rd(CMD_STOP_THRESH, 16'hf010);
    rd(CMD_CURR_OFFSET, 16'he000);
    rd(CMD_OV_LIMIT, 16'h0290);
    flags(4'h2);
    wr(CMD_STOP_THRESH, 16'hf014);
    rd(CMD_STOP_THRESH, 16'hf014);
    wr(CMD_STOP_THRESH, 16'he829);
    rd(CMD_STOP_THRESH, 16'hf015);
    flags(4'h2);
    wr(CMD_STOP_THRESH, 16'hf01f);
    rd(CMD_STOP_THRESH, 16'hf015);
    flags(4'hc);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    flags(4'h2);
    wr(CMD_STOP_THRESH, 16'hf000);
    flags(4'hc);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    start_thr = 5'h14;
    wr(CMD_STOP_THRESH, 16'hf014);
    flags(4'hc);
    rd(CMD_STOP_THRESH, 16'hf015);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    wr(CMD_STOP_THRESH, 16'hf013);
    rd(CMD_STOP_THRESH, 16'hf013);
    flags(4'h2);
    start_thr = 5'h1f;
    // offset wraps silently and trims the current path
    wr(CMD_CURR_OFFSET, 16'h0fff);
    rd(CMD_CURR_OFFSET, 16'he7ff);
    flags(4'h2);
    check({i_rd, oc_lim, ow_lim}, {16'h000f, 16'h003f, 16'hffef});
    wr(CMD_CURR_OFFSET, 16'h0005);
    rd(CMD_CURR_OFFSET, 16'he005);
    check({i_rd, oc_lim, ow_lim}, {16'h0015, 16'h0045, 16'hfff5});
    // overvoltage window against warning and ratio
    wr(CMD_OV_LIMIT, 16'h0200);
    rd(CMD_OV_LIMIT, 16'h0290);
    flags(4'hc);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    wr(CMD_OV_LIMIT, 16'h039a);
    flags(4'hc);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    wr(CMD_OV_LIMIT, 16'h0399);
    rd(CMD_OV_LIMIT, 16'h0399);
    flags(4'h2);
    ratio = 3'h2;
    wr(CMD_OV_LIMIT, 16'h0733);
    rd(CMD_OV_LIMIT, 16'h0733);
    // store-all strobe and image
    // strobe stands for the one cycle after the take, then drops
    fork
      wr(CMD_STORE_ALL, 16'h0000);
      begin
        @(posedge clk);
        #1;
        check({nv_store, nv_image}, {1'b1, 16'hf013, 16'he005, 16'h0730});
        @(posedge clk);
        #1;
        check(nv_store, 1'b0);
      end
    join
    rd(8'h50, 16'h0000);
    flags(4'h2);
    wrap_up();
  end
endmodule : pmbus_limit_config_regs_tb_top
